// ---- rtl/dual_data_pointer_select.sv ----
`default_nettype none
module dual_data_pointer_select (
	// clock and reset
	input  wire logic        i_clock,
	input  wire logic        i_rst,
	// special-function-register bus from the core
	input  wire logic [7:0]  i_sfr_addr,
	input  wire logic        i_sfr_wr,
	input  wire logic [7:0]  i_sfr_wdata,
	output logic      [7:0]  o_sfr_rdata,
	// double-speed mode from the first clock control register
	input  wire logic [7:0]  i_first_clock_control,
	// data pointer operations from the core
	input  wire logic [1:0]  i_ptr_op,
	input  wire logic [15:0] i_ptr_load_value,
	// code fetch address for the boot window
	input  wire logic [15:0] i_code_addr,
	// outputs
	output logic      [15:0] o_data_pointer,
	output logic             o_pointer_select,
	output logic             o_boot_rom_hit,
	output logic             o_boot_rom_map_enable,
	output logic             o_user_flag_bit,
	output logic             o_cpu_double_speed,
	output logic             o_spi_tick,
	output logic      [3:0]  o_spi_periods
);
	logic [7:0]  aux_reg;
	logic [7:0]  aux_next;
	logic [7:0]  clk2_reg;
	logic [15:0] pointer_zero_reg;
	logic [15:0] pointer_one_reg;
	logic [15:0] sel_ptr;
	logic [15:0] stepped_ptr;
	logic        pointer_select;
	logic        double_speed_mode;
	logic        serial_periph_speed_select;
	logic [3:0]  spi_periods;
	logic        spi_tick;
	logic        aux_wr;
	logic        clk2_wr;

	// masked write merge shared by both registers
	function automatic logic [7:0] merge_write(input logic [7:0] old_val,
		input logic [7:0] new_val, input logic [7:0] wmask);
		merge_write = (old_val & ~wmask) | (new_val & wmask);
	endfunction

	// address decode
	always_comb
	begin
		aux_wr  = 1'b0;
		clk2_wr = 1'b0;
		if (i_sfr_addr == data_pointer_sel_pkg::ADDR_AUX_PTR_CTRL)
			aux_wr = i_sfr_wr;
		else if (i_sfr_addr == data_pointer_sel_pkg::ADDR_CLK_CTRL_2)
			clk2_wr = i_sfr_wr;
	end

	// an increment by the core is a read-modify-write of value+1; with bit 2
	// stuck low the carry out of bit 1 stops there, so only bits 0 and 1 count
	always_comb
	begin
		aux_next = merge_write(aux_reg, i_sfr_wdata,
			data_pointer_sel_pkg::AUX_WMASK);
		aux_next[data_pointer_sel_pkg::BIT_ZERO_STUCK] = 1'b0;
	end

	// auxiliary pointer control register
	always_ff @(posedge i_clock)
	begin
		if (i_rst)
			aux_reg <= data_pointer_sel_pkg::AUX_RESET;
		else if (aux_wr)
			aux_reg <= aux_next;
	end

	// second clock control register
	always_ff @(posedge i_clock)
	begin
		if (i_rst)
			clk2_reg <= data_pointer_sel_pkg::CLK2_RESET;
		else if (clk2_wr)
			clk2_reg <= merge_write(clk2_reg, i_sfr_wdata,
				data_pointer_sel_pkg::CLK2_WMASK);
	end

	assign pointer_select = aux_reg[data_pointer_sel_pkg::BIT_POINTER_SELECT];
	assign double_speed_mode =
		i_first_clock_control[data_pointer_sel_pkg::BIT_DOUBLE_SPEED];
	assign serial_periph_speed_select = clk2_reg[data_pointer_sel_pkg::BIT_SPI_SPEED];

	// speed bit only counts in double-speed mode; standard mode is 12
	always_comb
	begin
		if (!double_speed_mode)
			spi_periods = data_pointer_sel_pkg::PERIODS_STD;
		else if (serial_periph_speed_select)
			spi_periods = data_pointer_sel_pkg::PERIODS_STD;
		else
			spi_periods = data_pointer_sel_pkg::PERIODS_FAST;
	end

	// peripheral tick for the serial interface
	periph_tick_div u_spi_div (
		.i_clock   (i_clock),
		.i_rst     (i_rst),
		.i_periods (spi_periods),
		.o_tick    (spi_tick)
	);

	// address match for the auxiliary register
	function automatic logic is_aux_addr(input logic [7:0] addr);
		is_aux_addr = (addr == data_pointer_sel_pkg::ADDR_AUX_PTR_CTRL);
	endfunction

	// address match for the second clock control register
	function automatic logic is_clk2_addr(input logic [7:0] addr);
		is_clk2_addr = (addr == data_pointer_sel_pkg::ADDR_CLK_CTRL_2);
	endfunction

	// one step of a data pointer; it wraps at the top of the space
	// and carries nothing out, as the core expects of an increment
	function automatic logic [15:0] pointer_step(input logic [15:0] ptr);
		pointer_step = ptr + 16'h0001;
	endfunction

	// fetch address inside the boot window; the window ends at the top
	// of the code space, so only the lower bound needs a compare
	function automatic logic in_boot_window(input logic [15:0] addr);
		in_boot_window = (addr >= data_pointer_sel_pkg::BOOT_ROM_BASE);
	endfunction

	// pointer zero; it moves only while it is the selected pointer,
	// so a block move keeps its source and destination apart, and a
	// reserved op code leaves it as it is
	always_ff @(posedge i_clock)
	begin
		if (i_rst)
			pointer_zero_reg <= 16'h0000;
		else if (!pointer_select)
		begin
			if (i_ptr_op == data_pointer_sel_pkg::PTR_LOAD)
				pointer_zero_reg <= i_ptr_load_value;
			else if (i_ptr_op == data_pointer_sel_pkg::PTR_INC)
				pointer_zero_reg <= pointer_step(pointer_zero_reg);
		end
	end

	// pointer one; the mirror of pointer zero, live only while the
	// select bit is set, so the two never move together in one cycle
	// and neither can lose an update to the other
	always_ff @(posedge i_clock)
	begin
		if (i_rst)
			pointer_one_reg <= 16'h0000;
		else if (pointer_select)
		begin
			if (i_ptr_op == data_pointer_sel_pkg::PTR_LOAD)
				pointer_one_reg <= i_ptr_load_value;
			else if (i_ptr_op == data_pointer_sel_pkg::PTR_INC)
				pointer_one_reg <= pointer_step(pointer_one_reg);
		end
	end

	// the selected pointer after this cycle's load or step
	always_comb
	begin
		stepped_ptr = pointer_select ? pointer_one_reg : pointer_zero_reg;
		if (i_ptr_op == data_pointer_sel_pkg::PTR_LOAD)
			stepped_ptr = i_ptr_load_value;
		else if (i_ptr_op == data_pointer_sel_pkg::PTR_INC)
			stepped_ptr = pointer_step(stepped_ptr);
	end

	// the pointer the core sees next; an aux write that flips the select
	// shows the other pointer, since this cycle's operation used the old
	always_comb
	begin
		sel_ptr = stepped_ptr;
		if (aux_wr && (aux_next[data_pointer_sel_pkg::BIT_POINTER_SELECT]
			!= pointer_select))
			sel_ptr = pointer_select ? pointer_zero_reg : pointer_one_reg;
	end

	// read data stands one cycle after the address; other addresses
	// read zero, so a stray read cannot leak a neighbour's contents;
	// reserved bits read back whatever was stored
	always_ff @(posedge i_clock)
	begin
		if (i_rst)
			o_sfr_rdata <= 8'h00;
		else if (is_aux_addr(i_sfr_addr))
			o_sfr_rdata <= aux_reg;
		else if (is_clk2_addr(i_sfr_addr))
			o_sfr_rdata <= clk2_reg;
		else
			o_sfr_rdata <= 8'h00;
	end

	// data pointer output, one register behind the combined view
	always_ff @(posedge i_clock)
	begin
		if (i_rst)
			o_data_pointer <= 16'h0000;
		else
			o_data_pointer <= sel_ptr;
	end

	// select output moves on the same edge as the register itself,
	// so the core never sees the flag and the pointer disagree;
	// costs a small mux in front of the flop
	always_ff @(posedge i_clock)
	begin
		if (i_rst)
			o_pointer_select <= 1'b0;
		else if (aux_wr)
			o_pointer_select <= aux_next[data_pointer_sel_pkg::BIT_POINTER_SELECT];
		else
			o_pointer_select <= pointer_select;
	end

	// boot map enable, one cycle behind the register; fetch logic
	// only needs it before the next instruction, so the lag is
	// harmless and keeps the output a plain flop
	always_ff @(posedge i_clock)
	begin
		if (i_rst)
			o_boot_rom_map_enable <= 1'b0;
		else
			o_boot_rom_map_enable <= aux_reg[data_pointer_sel_pkg::BIT_BOOT_MAP];
	end

	// boot window hit; with the map clear the window is ordinary code
	// space and the hit stays low whatever the address; the hit lags
	// the fetch address by one cycle
	always_ff @(posedge i_clock)
	begin
		if (i_rst)
			o_boot_rom_hit <= 1'b0;
		else
			o_boot_rom_hit <= aux_reg[data_pointer_sel_pkg::BIT_BOOT_MAP]
				&& in_boot_window(i_code_addr);
	end

	// user flag; no hardware reads it, it is kept for software alone,
	// and an increment of the register carries past it only if bit 2
	// were writable, which it is not
	always_ff @(posedge i_clock)
	begin
		if (i_rst)
			o_user_flag_bit <= 1'b0;
		else
			o_user_flag_bit <= aux_reg[data_pointer_sel_pkg::BIT_USER_FLAG];
	end

	// double-speed state as the core runs it; a new value from the
	// first clock control register shows here one cycle later, the
	// same lag as the period select below
	always_ff @(posedge i_clock)
	begin
		if (i_rst)
			o_cpu_double_speed <= 1'b0;
		else
			o_cpu_double_speed <= double_speed_mode;
	end

	// peripheral tick, registered once more so the output comes from
	// a flop; it costs one cycle of phase, which no user of the tick
	// can tell from a divider that started one cycle later
	always_ff @(posedge i_clock)
	begin
		if (i_rst)
			o_spi_tick <= 1'b0;
		else
			o_spi_tick <= spi_tick;
	end

	// period in use by the divider, shown for software and checks;
	// reset shows the standard ratio, matching the cleared speed bits
	// and standard mode
	always_ff @(posedge i_clock)
	begin
		if (i_rst)
			o_spi_periods <= data_pointer_sel_pkg::PERIODS_STD;
		else
			o_spi_periods <= spi_periods;
	end
endmodule
`default_nettype wire

// ---- rtl/data_pointer_sel_pkg.sv ----
`default_nettype none
package data_pointer_sel_pkg;
	// special-function-register addresses
	localparam logic [7:0] ADDR_AUX_PTR_CTRL = 8'hA2;
	localparam logic [7:0] ADDR_CLK_CTRL_2   = 8'hAF;
	localparam logic [7:0] ADDR_CLK_CTRL_1   = 8'h8F;
	// field positions
	localparam int BIT_POINTER_SELECT = 0;
	localparam int BIT_ZERO_STUCK     = 2;
	localparam int BIT_USER_FLAG      = 3;
	localparam int BIT_BOOT_MAP       = 5;
	localparam int BIT_SPI_SPEED      = 0;
	localparam int BIT_DOUBLE_SPEED   = 0;
	// reset values
	localparam logic [7:0] AUX_RESET   = 8'h00;
	localparam logic [7:0] CLK2_RESET  = 8'h00;
	// writable mask of the auxiliary register (bits 2 and 4 stuck at zero)
	localparam logic [7:0] AUX_WMASK   = 8'hEB;
	localparam logic [7:0] CLK2_WMASK  = 8'hFF;
	// boot rom window
	localparam logic [15:0] BOOT_ROM_BASE = 16'hF800;
	// oscillator periods per cycle
	localparam logic [3:0] PERIODS_FAST = 4'h6;
	localparam logic [3:0] PERIODS_STD  = 4'hC;
	localparam logic [3:0] PERIODS_ONE  = 4'h1;
	// pointer operation codes from the core
	typedef enum logic [1:0] {
		PTR_NONE = 2'h0,
		PTR_LOAD = 2'h1,
		PTR_INC  = 2'h2
	} ptr_op_t;
endpackage
`default_nettype wire

// ---- rtl/periph_tick_div.sv ----
`default_nettype none
// divides the oscillator clock to a one-cycle peripheral tick
module periph_tick_div (
	// clock and reset
	input  wire logic       i_clock,
	input  wire logic       i_rst,
	// selected ratio
	input  wire logic [3:0] i_periods,
	// tick
	output logic            o_tick
);
	logic [3:0] count_reg;

	// restart at the ratio end; a ratio change enters the compare at once and can cut the current period short
	always_ff @(posedge i_clock)
	begin
		if (i_rst)
		begin
			count_reg <= 4'h0;
			o_tick    <= 1'b0;
		end
		else if (count_reg + data_pointer_sel_pkg::PERIODS_ONE >= i_periods)
		begin
			count_reg <= 4'h0;
			o_tick    <= 1'b1;
		end
		else
		begin
			count_reg <= count_reg + data_pointer_sel_pkg::PERIODS_ONE;
			o_tick    <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ---- dv/data_pointer_sel_props.sv ----
`default_nettype none
module data_pointer_sel_props (
	// clock, reset, register bus
	input wire logic        i_clock,
	input wire logic        i_rst,
	input wire logic [7:0]  i_sfr_addr,
	input wire logic        i_sfr_wr,
	input wire logic [7:0]  i_sfr_wdata,
	input wire logic [7:0]  o_sfr_rdata,
	// core controls and outputs
	input wire logic [7:0]  i_first_clock_control,
	input wire logic [1:0]  i_ptr_op,
	input wire logic [15:0] i_ptr_load_value,
	input wire logic [15:0] i_code_addr,
	input wire logic [15:0] o_data_pointer,
	input wire logic        o_pointer_select,
	input wire logic        o_boot_rom_hit,
	input wire logic        o_boot_rom_map_enable,
	input wire logic        o_user_flag_bit,
	input wire logic [3:0]  o_spi_periods
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (i_rst);
	// an aux write also moves the select, so pointer checks skip it
	logic aux_wr;
	assign aux_wr = i_sfr_wr && i_sfr_addr == 8'hA2;
	chk_select_follows: assert property (
		aux_wr |=> o_pointer_select == $past(i_sfr_wdata[0]))
		else $error("select bit wrong");
	chk_stuck_zero: assert property (
		$past(i_sfr_addr) == 8'hA2 |-> !o_sfr_rdata[2])
		else $error("aux bit 2 read as one");
	chk_flag_delay: assert property (
		aux_wr |=> ##1 o_user_flag_bit == $past(i_sfr_wdata[3], 2))
		else $error("user flag wrong");
	chk_boot_hit: assert property (
		o_boot_rom_hit == (o_boot_rom_map_enable
			&& $past(i_code_addr) >= 16'hF800))
		else $error("boot window hit wrong");
	chk_ptr_load: assert property (
		i_ptr_op == 2'h1 && !aux_wr
			|=> o_data_pointer == $past(i_ptr_load_value))
		else $error("pointer load wrong");
	chk_ptr_inc: assert property (
		i_ptr_op == 2'h2 && !aux_wr
			|=> o_data_pointer == $past(o_data_pointer) + 16'h0001)
		else $error("pointer increment wrong");
	chk_std_speed: assert property (
		!i_first_clock_control[0] [*3] |-> o_spi_periods == 4'hC)
		else $error("spi period not 12 in standard mode");
	chk_reset_state: assert property (disable iff (1'b0)
		i_rst |=> o_sfr_rdata == 8'h00 && o_data_pointer == 16'h0000
			&& !o_pointer_select && o_spi_periods == 4'hC)
		else $error("reset state wrong");
endmodule
bind dual_data_pointer_select data_pointer_sel_props data_pointer_sel_props_i (
	.i_clock(i_clock), .i_rst(i_rst), .i_sfr_addr(i_sfr_addr),
	.i_sfr_wr(i_sfr_wr), .i_sfr_wdata(i_sfr_wdata),
	.o_sfr_rdata(o_sfr_rdata),
	.i_first_clock_control(i_first_clock_control),
	.i_ptr_op(i_ptr_op), .i_ptr_load_value(i_ptr_load_value),
	.i_code_addr(i_code_addr), .o_data_pointer(o_data_pointer),
	.o_pointer_select(o_pointer_select), .o_boot_rom_hit(o_boot_rom_hit),
	.o_boot_rom_map_enable(o_boot_rom_map_enable),
	.o_user_flag_bit(o_user_flag_bit), .o_spi_periods(o_spi_periods));
`default_nettype wire

// ---- dv/data_pointer_core_model.sv ----
`default_nettype none
module data_pointer_core_model (
	// clock
	input  wire logic       i_clock,
	// register bus
	output logic      [7:0] o_addr,
	output logic            o_wr,
	output logic      [7:0] o_wdata,
	input  wire logic [7:0] i_rdata
);
	timeunit 1ns;
	timeprecision 1ns;
	// one-cycle strobe; data inverted after release so stale data is no help
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clock);
		o_addr <= a;
		o_wr <= 1'b1;
		o_wdata <= d; // reserved bits passed on as the caller gives them
		@(posedge i_clock);
		o_wr <= 1'b0;
		o_wdata <= ~d;
	endtask
	// read data is registered, so it is taken one edge after the address
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge i_clock);
		o_addr <= a;
		@(posedge i_clock);
		#1 d = i_rdata;
	endtask
	initial
	begin
		o_addr = 8'h00;
		o_wr = 1'b0;
		o_wdata = 8'h00;
	end
endmodule
`default_nettype wire

// ---- dv/dual_data_pointer_select_tb_top.sv ----
`default_nettype none
module dual_data_pointer_select_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic        i_clock, i_rst, i_sfr_wr, o_pointer_select, o_boot_rom_hit;
	logic        o_boot_rom_map_enable, o_user_flag_bit, o_spi_tick;
	logic        o_cpu_double_speed;
	logic [7:0]  i_sfr_addr, i_sfr_wdata, o_sfr_rdata, i_first_clock_control;
	logic [1:0]  i_ptr_op;
	logic [3:0]  o_spi_periods;
	logic [15:0] i_ptr_load_value, i_code_addr, o_data_pointer;
	int          fails, n_compared, cyc;
	dual_data_pointer_select dual_data_pointer_select_i (
		.i_clock(i_clock), .i_rst(i_rst), .i_sfr_addr(i_sfr_addr),
		.i_sfr_wr(i_sfr_wr), .i_sfr_wdata(i_sfr_wdata),
		.o_sfr_rdata(o_sfr_rdata),
		.i_first_clock_control(i_first_clock_control),
		.i_ptr_op(i_ptr_op), .i_ptr_load_value(i_ptr_load_value),
		.i_code_addr(i_code_addr), .o_data_pointer(o_data_pointer),
		.o_pointer_select(o_pointer_select),
		.o_boot_rom_hit(o_boot_rom_hit),
		.o_boot_rom_map_enable(o_boot_rom_map_enable),
		.o_user_flag_bit(o_user_flag_bit),
		.o_cpu_double_speed(o_cpu_double_speed),
		.o_spi_tick(o_spi_tick), .o_spi_periods(o_spi_periods));
	data_pointer_core_model data_pointer_core_model_i (.i_clock(i_clock),
		.o_addr(i_sfr_addr), .o_wr(i_sfr_wr), .o_wdata(i_sfr_wdata),
		.i_rdata(o_sfr_rdata));
	task automatic chk(input string nm, input logic [15:0] seen, exp);
		n_compared++;
		if (seen !== exp)
		begin
			fails++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic report_and_stop();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic cyc_n(input int n);
		repeat (n) @(posedge i_clock);
		#1;
	endtask
	task automatic aux(input logic [15:0] exp);
		logic [7:0] v;
		data_pointer_core_model_i.rd(8'hA2, v);
		chk("aux", {8'h00, v}, exp);
	endtask
	// read-modify-write as the core does for an increment of the register
	task automatic t_inc(input logic [15:0] exp);
		logic [7:0] v;
		data_pointer_core_model_i.rd(8'hA2, v);
		data_pointer_core_model_i.wr(8'hA2, v + 8'h01);
		aux(exp);
	endtask
	task automatic op(input logic [1:0] o, input logic [15:0] v);
		i_ptr_op <= o;
		i_ptr_load_value <= v;
		cyc_n(1);
	endtask
	task automatic next_tick(output int n);
		n = 0;
		do
		begin
			cyc_n(1);
			n++;
		end while (o_spi_tick !== 1'b1 && n < 30);
		chk("tick seen", {15'h0000, o_spi_tick}, 16'h0001);
	endtask
	initial
	begin
		i_clock = 1'b0;
		forever #5 i_clock = ~i_clock;
	end
	// hang guard
	always @(posedge i_clock)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			fails++;
			report_and_stop();
		end
	end
	initial
	begin
		logic [7:0] v;
		int n;
		i_rst = 1'b1;
		i_first_clock_control = 8'h00;
		i_ptr_op = 2'h0;
		i_ptr_load_value = 16'h0000;
		i_code_addr = 16'h0000;
		repeat (3) @(posedge i_clock);
		i_rst <= 1'b0;
		data_pointer_core_model_i.rd(8'hAF, v);
		chk("clk2 speed bit", {15'h0000, v[0]}, 16'h0000);
		data_pointer_core_model_i.rd(8'hA2, v);
		chk("aux fixed bits", {8'h00, v & 8'h05}, 16'h0000);
		data_pointer_core_model_i.wr(8'hA2, 8'h2D);
		aux(16'h0029);
		chk("select", o_pointer_select, 16'h0001);
		chk("flag", o_user_flag_bit, 16'h0001);
		chk("boot map", o_boot_rom_map_enable, 16'h0001);
		i_code_addr <= 16'hF800;
		cyc_n(2);
		chk("boot hit", o_boot_rom_hit, 16'h0001);
		i_code_addr <= 16'hF7FF;
		cyc_n(2);
		chk("boot miss", o_boot_rom_hit, 16'h0000);
		t_inc(16'h002A);
		t_inc(16'h002B);
		data_pointer_core_model_i.wr(8'hA2, 8'h08);
		op(2'h1, 16'h1234);
		op(2'h0, 16'h0000);
		t_inc(16'h0009);
		op(2'h1, 16'hABCD);
		op(2'h2, 16'h0000);
		op(2'h0, 16'h0000);
		chk("pointer one", o_data_pointer, 16'hABCE);
		t_inc(16'h000A);
		chk("pointer zero", o_data_pointer, 16'h1234);
		i_code_addr <= 16'hFFFF;
		cyc_n(2);
		chk("boot off", o_boot_rom_hit, 16'h0000);
		chk("std", {12'h000, o_spi_periods}, 16'h000C);
		i_first_clock_control <= 8'h01;
		cyc_n(3);
		chk("fast", {12'h000, o_spi_periods}, 16'h0006);
		chk("x2", o_cpu_double_speed, 16'h0001);
		next_tick(n);
		next_tick(n);
		next_tick(n);
		chk("tick gap", n[15:0], 16'h0006);
		data_pointer_core_model_i.wr(8'hAF, 8'h01);
		cyc_n(3);
		chk("slow", {12'h000, o_spi_periods}, 16'h000C);
		next_tick(n);
		next_tick(n);
		next_tick(n);
		chk("slow tick gap", n[15:0], 16'h000C);
		report_and_stop();
	end
endmodule
`default_nettype wire
